// >>> bench/jisp_ctl_model.sv
// external boundary-scan programming controller on the test link pins
`timescale 1ns/1ps
module jisp_ctl_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  // test clock stands low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // data-out read late in the high phase: the block's synchroniser lag
  // can reach half a test clock period (four system clocks)
  task automatic clk1(input logic ms, input logic di, output logic q);
    tms_o = ms;
    tdi_o = di;
    #160 tck_o = 1'b1;
    #150 q = tdo_i;
    #10 tck_o = 1'b0;
  endtask : clk1

  // odd offset keeps test clock edges away from system clock edges
  task automatic reset_tap();
    logic d;
    #13;
    repeat (5) clk1(1'b1, 1'b1, d);
    clk1(1'b0, 1'b1, d);
  endtask : reset_tap

  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic d;
    #13;
    dout = '0;
    clk1(1'b1, 1'b0, d);
    if (ir) clk1(1'b1, 1'b0, d);
    clk1(1'b0, 1'b0, d);
    clk1(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      clk1(i == n - 1, din[i], d);
      dout[i] = d;
    end
    clk1(1'b1, 1'b0, d);
    clk1(1'b0, 1'b0, d);
  endtask : scan
endmodule : jisp_ctl_model

// >>> bench/testbench.sv
// self-checking bench for the serial programming port control block
`timescale 1ns/1ps
module testbench;
  import jisp_pkg::*;
  logic        mclk, rst, wr_s, rd_s, cfg, blank, pld, busy, ferr;
  logic        jon, wstb, tck, tms, tdi;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [6:0]  gout, goe, gin, pin, po, poe;
  logic [15:0] word, d16;
  int          failures, check_count, stb_count;

  // undriven pins sit at their pull-up level, except mode, clock and data-in, which the controller drives
  assign pin = (poe & {1'b1, tdi, 3'b111, tck, tms}) | (~poe & po);

  jisp_port uut (.mclk_i(mclk), .sys_rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .cfg_jtag_pins_i(cfg), .blank_device_i(blank),
    .pld_jtag_en_i(pld), .flash_busy_i(busy), .flash_err_i(ferr),
    .gpio_out_i(gout), .gpio_oe_n_i(goe), .gpio_in_o(gin),
    .port_c_i(pin), .port_c_o(po), .port_c_oe_n_o(poe),
    .jtag_on_o(jon), .isp_word_o(word), .isp_word_stb_o(wstb));

  jisp_ctl_model u_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(pin[6]));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge mclk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // whole run needs well under 100 us
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end

  always @(posedge mclk) if (wstb === 1'b1) stb_count++;

  initial begin
    {rst, wr_s, rd_s, cfg, blank, pld, busy, ferr} = 8'h80;
    addr  = 4'h0;
    wdata = 8'h00;
    gout  = 7'h55;
    goe   = 7'h00;
    failures = 0;
    check_count = 0;
    stb_count = 0;
    repeat (4) @(posedge mclk);
    #1 chk(16'(jon), 16'h0000);
    @(posedge mclk);
    rst <= 1'b0;
    cyc(4);
    // user drives every pin; the four test pins must follow it when off
    chk(16'(jon), 16'h0000);
    chk(16'(po & 7'h67), 16'h0045);
    chk(16'(poe & 7'h67), 16'h0000);
    chk(16'(gin[2]), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      cfg   <= (i == 0);
      pld   <= (i == 1);
      blank <= (i == 2);
      if (i == 3) wr(4'h0, 8'h01);
      cyc(4);
      chk(16'(jon), 16'h0001);
      chk(16'(poe & 7'h63), 16'h0063);
      rd(4'h1, 8'h01);
    end
    rd(4'h0, 8'h01);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h01);
    rd(4'h7, 8'h00);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    cyc(3);
    chk(16'(jon), 16'h0000);
    rd(4'h0, 8'h00);
    @(posedge mclk);
    cfg <= 1'b1;
    cyc(4);
    u_ctl.reset_tap();
    rd(4'h2, {4'h0, TAP_IDLE});
    // extension config before activation must be ignored
    u_ctl.scan(1'b1, 4, 16'h0002, d16);
    u_ctl.scan(1'b0, 2, 16'h0001, d16);
    cyc(4);
    chk(16'(poe[6]), 16'h0001);
    rd(4'h1, 8'h01);
    u_ctl.scan(1'b1, 4, 16'h0001, d16);
    cyc(4);
    chk(16'(poe[6]), 16'h0000);
    rd(4'h1, 8'h03);
    u_ctl.scan(1'b1, 4, 16'h000f, d16);
    chk(d16, 16'h0001);
    u_ctl.scan(1'b0, 4, 16'h000b, d16);
    chk(d16, 16'h0006);
    u_ctl.scan(1'b1, 4, 16'h0002, d16);
    u_ctl.scan(1'b0, 2, 16'h0001, d16);
    cyc(4);
    chk(16'(poe[4:3]), 16'h0003);
    rd(4'h1, 8'h07);
    @(posedge mclk);
    busy <= 1'b1;
    ferr <= 1'b1;
    @(posedge mclk);
    ferr <= 1'b0;
    cyc(4);
    chk(16'({po[4:3], poe[4:3]}), 16'h0000);
    rd(4'h1, 8'h37);
    @(posedge mclk);
    busy <= 1'b0;
    u_ctl.scan(1'b0, 2, 16'h0003, d16);
    cyc(4);
    chk(16'({po[4:3], poe[4:3]}), 16'h0004);
    @(posedge mclk);
    busy <= 1'b1;
    cyc(4);
    chk(16'({po[4:3], poe[4:3]}), 16'h0008);
    u_ctl.scan(1'b1, 4, 16'h0003, d16);
    u_ctl.scan(1'b0, 16, 16'ha5c3, d16);
    cyc(4);
    chk(16'(d16[1:0]), 16'h0001);
    chk(word, 16'ha5c3);
    chk(16'(stb_count), 16'h0001);
    @(posedge mclk);
    cfg <= 1'b0;
    cyc(4);
    chk(16'(jon), 16'h0000);
    chk(16'(poe & 7'h67), 16'h0000);
    rd(4'h1, 8'h28);
    rd(4'h2, {4'h0, TAP_RESET});
    report_and_stop();
  end
endmodule : testbench

// >>> rtl/jisp_defs.svh
// constants of the serial in-system programming port control block
// What this block does
// - external controller programs all or part of flash and logic, host idle
// - no boundary-scan cells; port stays in bypass for other chain members
// - test pins enabled when pin config, logic equation or host bit is true
// - enabled but not activated: mode, clock, data-in, data-out all inputs
// - after the activating command data-out is driven, channel functional
// - combined enable false: the four test pins are user general I/O
// - blank factory device has the four test pins enabled by default
// - host enable bit in control register; any reset clears it
// - status and error pins enabled together, only by a serial command
// - error pin driven low when flash erase or program ends in error
// - status pin 1 in flash read mode, 0 while program or erase runs
// - status and error pins open-drain by default, push-pull selectable
`ifndef JISP_DEFS_SVH
`define JISP_DEFS_SVH

`define JISP_ADDR_W        4
`define JISP_DATA_W        8
`define JISP_PORT_W        7
`define JISP_IR_W          4
`define JISP_DR_W          16

`define JISP_PORT_C_BIT0   0
`define JISP_PORT_C_BIT1   1
`define JISP_PORT_C_BIT3   3
`define JISP_PORT_C_BIT4   4
`define JISP_PORT_C_BIT5   5
`define JISP_PORT_C_BIT6   6
`define JISP_PORT_ALL_IN   7'h7f

`define JISP_IR_CAPTURE    4'h1
`define JISP_IR_ACTIVATE   4'h1
`define JISP_IR_EXTCFG     4'h2
`define JISP_IR_PROGRAM    4'h3
`define JISP_IR_BYPASS     4'hf

`define JISP_OFS_CTRL      4'h0
`define JISP_OFS_STATUS    4'h1
`define JISP_OFS_TAPST     4'h2

`define JISP_CTRL_EN_BIT   0
`define JISP_ST_ON_BIT     0
`define JISP_ST_ACT_BIT    1
`define JISP_ST_EXT_BIT    2
`define JISP_ST_PP_BIT     3
`define JISP_ST_ERR_BIT    4
`define JISP_ST_BUSY_BIT   5

`endif

// >>> rtl/jisp_pkg.sv
// types of the serial in-system programming port control block
`include "jisp_defs.svh"
package jisp_pkg;

  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0, TAP_IDLE    = 4'h1, TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3, TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7, TAP_UPD_DR = 4'h8,
    TAP_SEL_IR  = 4'h9, TAP_CAP_IR  = 4'ha, TAP_SHIFT_IR = 4'hb,
    TAP_EXIT1_IR = 4'hc, TAP_PAUSE_IR = 4'hd, TAP_EXIT2_IR = 4'he,
    TAP_UPD_IR  = 4'hf
  } jisp_tap_t;

  typedef struct packed {
    logic [`JISP_PORT_W-1:0] o;
    logic [`JISP_PORT_W-1:0] oe_n;
  } jisp_pins_t;

  typedef struct packed {
    logic [`JISP_PORT_W-1:0] s1;
    logic [`JISP_PORT_W-1:0] s2;
    logic                    tck_d;
    logic                    jtag_on;
    logic                    ctrl_en;
    logic                    act;
    logic                    ext_en;
    logic                    ext_pp;
    logic [`JISP_IR_W-1:0]   ir;
    logic [`JISP_IR_W-1:0]   ir_sh;
    logic [`JISP_DR_W-1:0]   dr_sh;
    logic                    tdo;
    logic                    busy;
    logic                    err;
    logic [`JISP_DR_W-1:0]   word;
    logic                    word_stb;
    jisp_pins_t              pins;
    logic [`JISP_PORT_W-1:0] pin_in;
    logic [`JISP_DATA_W-1:0] rdata;
  } jisp_state_t;

endpackage : jisp_pkg

// >>> rtl/jisp_port.sv
// serial programming port: pin enable, tap data path, extension pins
`timescale 1ns/1ps
`include "jisp_defs.svh"
module jisp_port
  import jisp_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [`JISP_ADDR_W-1:0] reg_addr_i,
  input  wire logic [`JISP_DATA_W-1:0] reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [`JISP_DATA_W-1:0] reg_rdata_o,
  input  wire logic                    cfg_jtag_pins_i,
  input  wire logic                    blank_device_i,
  input  wire logic                    pld_jtag_en_i,
  input  wire logic                    flash_busy_i,
  input  wire logic                    flash_err_i,
  input  wire logic [`JISP_PORT_W-1:0] gpio_out_i,
  input  wire logic [`JISP_PORT_W-1:0] gpio_oe_n_i,
  output logic      [`JISP_PORT_W-1:0] gpio_in_o,
  input  wire logic [`JISP_PORT_W-1:0] port_c_i,
  output logic      [`JISP_PORT_W-1:0] port_c_o,
  output logic      [`JISP_PORT_W-1:0] port_c_oe_n_o,
  output logic                         jtag_on_o,
  output logic      [`JISP_DR_W-1:0]   isp_word_o,
  output logic                         isp_word_stb_o
);

  jisp_state_t q, d;
  jisp_tap_t   tap;
  logic        tck_rise;
  logic        tck_fall;
  logic        tms;
  logic        tdi;

  // only the second synchroniser stage is looked at
  assign tms      = q.s2[`JISP_PORT_C_BIT0];
  assign tdi      = q.s2[`JISP_PORT_C_BIT5];
  assign tck_rise = q.s2[`JISP_PORT_C_BIT1] & ~q.tck_d;
  assign tck_fall = ~q.s2[`JISP_PORT_C_BIT1] & q.tck_d;

  jisp_tap u_tap (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .step_i    (tck_rise),
    .tms_i     (tms),
    .hold_i    (~q.jtag_on),
    .state_o   (tap)
  );

  // commands other than activate only count once the port is activated
  function automatic logic [`JISP_IR_W-1:0] eff_ir(input jisp_state_t s);
    eff_ir = s.act ? s.ir : `JISP_IR_BYPASS;
  endfunction : eff_ir

  // unknown instructions select the one-bit bypass register
  function automatic logic [`JISP_DR_W-1:0] dr_capture(
    input logic [`JISP_IR_W-1:0] ir,
    input jisp_state_t           s
  );
    dr_capture = '0;
    case (ir)
      `JISP_IR_EXTCFG: begin
        dr_capture[0] = s.ext_en;
        dr_capture[1] = s.ext_pp;
      end
      `JISP_IR_PROGRAM: begin
        dr_capture[0] = s.busy;
        dr_capture[1] = s.err;
      end
      default: dr_capture = '0;
    endcase
  endfunction : dr_capture

  function automatic logic [`JISP_DR_W-1:0] dr_shift(
    input logic [`JISP_IR_W-1:0] ir,
    input logic [`JISP_DR_W-1:0] sh,
    input logic                  din
  );
    dr_shift = sh;
    case (ir)
      `JISP_IR_EXTCFG: begin
        dr_shift[0] = sh[1];
        dr_shift[1] = din;
      end
      `JISP_IR_PROGRAM: dr_shift = {din, sh[`JISP_DR_W-1:1]};
      default:          dr_shift[0] = din;
    endcase
  endfunction : dr_shift

  function automatic logic [`JISP_DATA_W-1:0] reg_read(
    input logic [`JISP_ADDR_W-1:0] a,
    input jisp_state_t             s,
    input jisp_tap_t               t
  );
    reg_read = '0;
    case (a)
      `JISP_OFS_CTRL:   reg_read[`JISP_CTRL_EN_BIT] = s.ctrl_en;
      `JISP_OFS_STATUS: begin
        reg_read[`JISP_ST_ON_BIT]   = s.jtag_on;
        reg_read[`JISP_ST_ACT_BIT]  = s.act;
        reg_read[`JISP_ST_EXT_BIT]  = s.ext_en;
        reg_read[`JISP_ST_PP_BIT]   = s.ext_pp;
        reg_read[`JISP_ST_ERR_BIT]  = s.err;
        reg_read[`JISP_ST_BUSY_BIT] = s.busy;
      end
      `JISP_OFS_TAPST:  reg_read[`JISP_IR_W-1:0] = t;
      default:          reg_read = '0;
    endcase
  endfunction : reg_read

  always_comb begin
    d          = q;
    d.s1       = port_c_i;
    d.s2       = q.s1;
    d.tck_d    = q.s2[`JISP_PORT_C_BIT1];
    d.pin_in   = q.s2;
    d.word_stb = 1'b0;
    d.busy     = flash_busy_i;
    d.rdata    = '0;
    // three enable sources, a blank part counts as a fixed pin choice
    d.jtag_on  = cfg_jtag_pins_i | blank_device_i | pld_jtag_en_i
               | q.ctrl_en;
    if (reg_wr_i && reg_addr_i == `JISP_OFS_CTRL) begin
      d.ctrl_en = reg_wdata_i[`JISP_CTRL_EN_BIT];
    end
    if (reg_rd_i) begin
      d.rdata = reg_read(reg_addr_i, q, tap);
    end
    // error holds until the next operation starts; a new error wins
    if (flash_busy_i && !q.busy) begin
      d.err = 1'b0;
    end
    if (flash_err_i) begin
      d.err = 1'b1;
    end
    if (!q.jtag_on) begin
      d.act    = 1'b0;
      d.ext_en = 1'b0;
    end else if (tck_rise) begin
      case (tap)
        TAP_RESET:    d.ir = `JISP_IR_BYPASS;
        TAP_CAP_IR:   d.ir_sh = `JISP_IR_CAPTURE;
        TAP_SHIFT_IR: d.ir_sh = {tdi, q.ir_sh[`JISP_IR_W-1:1]};
        TAP_UPD_IR: begin
          d.ir = q.ir_sh;
          if (q.ir_sh == `JISP_IR_ACTIVATE) begin
            d.act = 1'b1;
          end
        end
        TAP_CAP_DR:   d.dr_sh = dr_capture(eff_ir(q), q);
        TAP_SHIFT_DR: d.dr_sh = dr_shift(eff_ir(q), q.dr_sh, tdi);
        TAP_UPD_DR: begin
          case (eff_ir(q))
            `JISP_IR_EXTCFG: begin
              d.ext_en = q.dr_sh[0];
              d.ext_pp = q.dr_sh[1];
            end
            `JISP_IR_PROGRAM: begin
              d.word     = q.dr_sh;
              d.word_stb = 1'b1;
            end
            default: d.word_stb = 1'b0;
          endcase
        end
        default: d.ir = q.ir;
      endcase
    end
    // data-out moves only on the falling test clock
    if (q.jtag_on && tck_fall) begin
      if (tap == TAP_SHIFT_IR) begin
        d.tdo = q.ir_sh[0];
      end else if (tap == TAP_SHIFT_DR) begin
        d.tdo = q.dr_sh[0];
      end
    end
    d.pins.o    = gpio_out_i;
    d.pins.oe_n = gpio_oe_n_i;
    if (q.jtag_on) begin
      d.pins.o[`JISP_PORT_C_BIT0]    = 1'b0;
      d.pins.oe_n[`JISP_PORT_C_BIT0] = 1'b1;
      d.pins.o[`JISP_PORT_C_BIT1]    = 1'b0;
      d.pins.oe_n[`JISP_PORT_C_BIT1] = 1'b1;
      d.pins.o[`JISP_PORT_C_BIT5]    = 1'b0;
      d.pins.oe_n[`JISP_PORT_C_BIT5] = 1'b1;
      d.pins.o[`JISP_PORT_C_BIT6]    = q.tdo;
      d.pins.oe_n[`JISP_PORT_C_BIT6] = ~q.act;
      if (q.ext_en) begin
        // open drain only ever pulls low, so several parts can share a wire
        d.pins.o[`JISP_PORT_C_BIT3]    = q.ext_pp & ~q.busy;
        d.pins.oe_n[`JISP_PORT_C_BIT3] = q.ext_pp ? 1'b0 : ~q.busy;
        d.pins.o[`JISP_PORT_C_BIT4]    = q.ext_pp & ~q.err;
        d.pins.oe_n[`JISP_PORT_C_BIT4] = q.ext_pp ? 1'b0 : ~q.err;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q           <= '0;
      q.ir        <= `JISP_IR_BYPASS;
      q.pins.oe_n <= `JISP_PORT_ALL_IN;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o    = q.rdata;
  assign gpio_in_o      = q.pin_in;
  assign port_c_o       = q.pins.o;
  assign port_c_oe_n_o  = q.pins.oe_n;
  assign jtag_on_o      = q.jtag_on;
  assign isp_word_o     = q.word;
  assign isp_word_stb_o = q.word_stb;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_enable_or_sources: assert property (
    ##1 jtag_on_o == $past(cfg_jtag_pins_i | blank_device_i
                           | pld_jtag_en_i | q.ctrl_en))
    else $error("test pin enable is not the or of its sources");

  chk_idle_all_inputs: assert property (
    (q.jtag_on && !q.act) |=>
      port_c_oe_n_o[`JISP_PORT_C_BIT6] && port_c_oe_n_o[`JISP_PORT_C_BIT0]
      && port_c_oe_n_o[`JISP_PORT_C_BIT1] && port_c_oe_n_o[`JISP_PORT_C_BIT5])
    else $error("test pin driven before activation");

  chk_tdo_driven_active: assert property (
    (q.jtag_on && q.act) |=> !port_c_oe_n_o[`JISP_PORT_C_BIT6]
                             && port_c_o[`JISP_PORT_C_BIT6] == $past(q.tdo))
    else $error("data-out not driven after activation");

  chk_gpio_release: assert property (
    !q.jtag_on |=> port_c_oe_n_o == $past(gpio_oe_n_i)
                   && port_c_o == $past(gpio_out_i))
    else $error("pins not handed back to general I/O");

  chk_host_bit_write: assert property (
    (reg_wr_i && reg_addr_i == `JISP_OFS_CTRL) |=> ##1
      jtag_on_o == ($past(reg_wdata_i[`JISP_CTRL_EN_BIT], 2)
                    | $past(cfg_jtag_pins_i | blank_device_i
                            | pld_jtag_en_i)))
    else $error("host enable bit does not reach the pin enable");

  chk_ext_needs_cmd: assert property (
    (!q.act || !q.jtag_on) |=> !q.ext_en)
    else $error("extension pins enabled without a command");

  chk_error_pin_low: assert property (
    (q.err && q.jtag_on && q.ext_en) |=> !port_c_o[`JISP_PORT_C_BIT4]
                                         && !port_c_oe_n_o[`JISP_PORT_C_BIT4])
    else $error("error pin not pulled low on a flash error");

  chk_status_level: assert property (
    (q.jtag_on && q.ext_en && q.ext_pp) |=>
      port_c_o[`JISP_PORT_C_BIT3] == !$past(q.busy))
    else $error("status pin does not follow flash busy");

  chk_open_drain: assert property (
    (q.jtag_on && q.ext_en && !q.ext_pp) |=>
      (!port_c_o[`JISP_PORT_C_BIT3] && !port_c_o[`JISP_PORT_C_BIT4]
       && port_c_oe_n_o[`JISP_PORT_C_BIT3] == !$past(q.busy)))
    else $error("open-drain extension pin drives high");

  chk_bypass_capture: assert property (
    (q.jtag_on && tck_rise && tap == TAP_CAP_DR && !q.act) |=> !q.dr_sh[0])
    else $error("bypass register does not capture zero");

  chk_tdo_on_fall: assert property (
    $changed(q.tdo) |-> $past(tck_fall))
    else $error("data-out changed away from a falling test clock");

  cov_activate: cover property ($rose(q.act));
  cov_ext_enable: cover property ($rose(q.ext_en) && q.ext_pp == 1'b0);
  cov_program_word: cover property (isp_word_stb_o);
  cov_gpio_return: cover property ($fell(jtag_on_o));

endmodule : jisp_port

// >>> rtl/jisp_tap.sv
// tap controller state machine, stepped on each rising test clock
`timescale 1ns/1ps
module jisp_tap
  import jisp_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  sys_rst_i,
  input  wire logic  step_i,
  input  wire logic  tms_i,
  input  wire logic  hold_i,
  output jisp_tap_t  state_o
);

  typedef struct packed {
    jisp_tap_t st;
  } jisp_tap_reg_t;

  jisp_tap_reg_t q, d;

  function automatic jisp_tap_t tap_next(input jisp_tap_t s, input logic m);
    case (s)
      TAP_RESET:    tap_next = m ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     tap_next = m ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   tap_next = m ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_next = m ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   tap_next = m ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_next = m ? TAP_SEL_DR   : TAP_IDLE;
      default:      tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  always_comb begin
    d = q;
    if (hold_i) begin
      d.st = TAP_RESET;
    end else if (step_i) begin
      d.st = tap_next(q.st, tms_i);
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q.st <= TAP_RESET;
    end else begin
      q <= d;
    end
  end

  assign state_o = q.st;

endmodule : jisp_tap
